// ---- hdl/pmv_params.svh ----
// Purpose: Numeric constants of the program memory unit
// Assumes: Included by the package and by the store, stack and core files
// Notes:   Definitions only
`ifndef PMV_PARAMS_SVH
`define PMV_PARAMS_SVH

// =====================================================================
// Store geometry
`define PMV_ADDR_W     12
`define PMV_WORD_W     15
`define PMV_DEPTH      4096
`define PMV_TBLP_W     8
`define PMV_LOW_W      8

// =====================================================================
// Fixed entry points
`define PMV_VEC_RESET  12'h000
`define PMV_VEC_EXT0   12'h004
`define PMV_VEC_EXT1   12'h008
`define PMV_VEC_TMR0   12'h00C
`define PMV_VEC_TMR1   12'h010
`define PMV_VEC_MF0    12'h014
`define PMV_VEC_MF1    12'h018
`define PMV_NUM_VEC    6

// =====================================================================
// Table read and stack
`define PMV_LAST_PAGE  4'hF
`define PMV_TABLE_HIGH_BYTE_RST   8'h00
`define PMV_STK_DEPTH  6
`define PMV_SP_W       3

`endif

// ---- hdl/pmv_pkg.sv ----
// Purpose: Types shared by the program memory unit
// Assumes: pmv_params.svh holds the numbers
// Notes:   One state struct per module
`include "pmv_params.svh"

package pmv_pkg;

  // ===================================================================
  // Basic words
  typedef logic [`PMV_ADDR_W-1:0] pmv_addr_t;   // Program address
  typedef logic [`PMV_WORD_W-1:0] pmv_word_t;   // Program word

  // ===================================================================
  // Operation posted by the core for the presented instruction
  typedef enum logic [2:0] {
    PMV_OP_NEXT     = 3'h0,
    PMV_OP_SKIP     = 3'h1,
    PMV_OP_JUMP     = 3'h2,
    PMV_OP_CALL     = 3'h3,
    PMV_OP_RET      = 3'h4,
    PMV_OP_PCL      = 3'h5,
    PMV_OP_TBL_CUR  = 3'h6,
    PMV_OP_TBL_LAST = 3'h7
  } pmv_op_t;

  // Sequencer states
  typedef enum logic [0:0] {
    PMV_ST_RUN = 1'h0,
    PMV_ST_TBL = 1'h1
  } pmv_state_t;

  // ===================================================================
  // Module state structs
  typedef struct packed {
    pmv_state_t                   state;      // Sequencer
    pmv_addr_t                    pc;         // Program counter
    logic [`PMV_TBLP_W-1:0]       tblp;       // Table pointer
    logic [`PMV_LOW_W-1:0]        thb;        // Table high byte
    logic [`PMV_LOW_W-1:0]        tbl_data;   // Low byte of table word
    logic [`PMV_LOW_W-1:0]        tbl_dest;   // Destination of low byte
    logic                         tbl_wr;     // Low byte write pulse
    logic                         busy;       // Table read in flight
    logic                         ifv;        // Fetch word valid
    logic                         ack;        // Interrupt taken pulse
    logic [2:0]                   vec;        // Taken vector index
    logic [`PMV_NUM_VEC-1:0]      pend;       // Request flags
    logic                         stk_full;   // Stack full copy
    logic [1:0]                   s1;         // Pin sync stage 1
    logic [1:0]                   s2;         // Pin sync stage 2
    logic [1:0]                   prev;       // Pin edge history
  } pmv_core_st_t;

  typedef struct packed {
    logic [`PMV_SP_W-1:0]                     sp;   // Used levels
    logic [`PMV_STK_DEPTH-1:0][`PMV_ADDR_W-1:0] ent; // Saved counters
  } pmv_stk_st_t;

  typedef struct packed {
    pmv_word_t rdata;                               // Registered read
  } pmv_rom_st_t;

endpackage

// ---- hdl/pmv_if.sv ----
// Purpose: Carriers between the core and its store and stack
// Assumes: pmv_pkg compiled first
// Notes:   No clocking blocks
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Return address stack link
interface pmv_stk_if;
  logic              push;       // Save push_data
  logic              pop;        // Drop top level
  pmv_pkg::pmv_addr_t push_data; // Address to save
  pmv_pkg::pmv_addr_t top_data;  // Top level
  logic              full;       // All levels used
  modport core  (output push, pop, push_data, input top_data, full);
  modport stack (input push, pop, push_data, output top_data, full);
endinterface

// =====================================================================
// Program store link
interface pmv_rom_if;
  pmv_pkg::pmv_addr_t rd_addr;   // Read address
  pmv_pkg::pmv_word_t rd_data;   // Registered word
  logic              ld_we;      // Load strobe
  pmv_pkg::pmv_addr_t ld_addr;   // Load address
  pmv_pkg::pmv_word_t ld_data;   // Load word
  modport core (output rd_addr, ld_we, ld_addr, ld_data, input rd_data);
  modport rom  (input rd_addr, ld_we, ld_addr, ld_data, output rd_data);
endinterface

`default_nettype wire

// ---- hdl/pmv_rom.sv ----
// Purpose: One-time-programmable program store, 4K by 15
// Assumes: Load port stands in for the programmer
// Notes:   Read data leave through a register
`timescale 1ns/1ps
`default_nettype none
`include "pmv_params.svh"

module pmv_rom
  import pmv_pkg::*;
(
  input  wire logic clk_sys,   // System clock
  input  wire logic rst_n,     // Async reset
  input  wire logic clk_en,    // Freeze when low
  pmv_rom_if.rom    rom        // Core link
);

  // ===================================================================
  // Storage
  pmv_word_t   mem [`PMV_DEPTH];  // Word array
  pmv_rom_st_t st_r;              // Read register
  pmv_rom_st_t st_nxt;            // Its next value

  // Load writes, no reset on the array
  always_ff @(posedge clk_sys) begin
    if (clk_en && rom.ld_we) begin
      mem[rom.ld_addr] <= rom.ld_data;
    end
  end

  // Read the addressed word
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = mem[rom.rd_addr];
  end

  // Read register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign rom.rd_data = st_r.rdata;

endmodule

`default_nettype wire

// ---- hdl/pmv_stack.sv ----
// Purpose: Return address stack of the program counter
// Assumes: Core never pushes and pops in one cycle
// Notes:   A push when full overwrites the top level
`timescale 1ns/1ps
`default_nettype none
`include "pmv_params.svh"

module pmv_stack
  import pmv_pkg::*;
(
  input  wire logic clk_sys,   // System clock
  input  wire logic rst_n,     // Async reset
  input  wire logic clk_en,    // Freeze when low
  pmv_stk_if.stack  stk        // Core link
);

  // ===================================================================
  // State
  localparam logic [`PMV_SP_W-1:0] SpFull = `PMV_SP_W'(`PMV_STK_DEPTH);

  pmv_stk_st_t st_r;    // Pointer and levels
  pmv_stk_st_t st_nxt;  // Next value

  // Push and pop
  always_comb begin
    st_nxt = st_r;
    if (stk.push) begin
      if (st_r.sp == SpFull) begin
        // Overflow: software hazard, keep the newest address
        st_nxt.ent[SpFull-1'b1] = stk.push_data;
      end else begin
        st_nxt.ent[st_r.sp] = stk.push_data;
        st_nxt.sp           = st_r.sp + 1'b1;
      end
    end else if (stk.pop && st_r.sp != '0) begin
      st_nxt.sp = st_r.sp - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign stk.top_data = (st_r.sp == '0) ? '0 : st_r.ent[st_r.sp - 1'b1];
  assign stk.full     = (st_r.sp == SpFull);

endmodule

`default_nettype wire

// ---- hdl/pmv_core.sv ----
// Purpose: Program memory unit: fetch, vectors, table reads
// Assumes: Core logic on clk_sys posts one op per presented word
// Notes:   Interrupts are taken only in cycles with no op posted
//
// How it works
// - 4K by 15 store addressed by counter
// - Reset starts execution at 000H
// - External interrupt 0 enters at 004H
// - External interrupt 1 enters at 008H
// - Timer 0 overflow enters at 00CH
// - Timer 1 overflow enters at 010H
// - Serial and C/R-F share vector 014H
// - Clock, time base, ADC, peripheral share 018H
// - Full stack holds flag, no acknowledge
// - Push on call or interrupt, pop on return
// - 8-bit table pointer gives low address
// - Current page read uses counter upper bits
// - Last page read forces upper bits ones
// - Low byte to destination, rest to high
// - Unused high byte bits read zero
// - High byte register is read-only
// - Table read takes two cycles
`timescale 1ns/1ps
`default_nettype none
`include "pmv_params.svh"

module pmv_core
  import pmv_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  input  wire logic                       op_valid,
  input  wire pmv_op_t                    op_code,
  input  wire logic [`PMV_ADDR_W-1:0]     op_addr,
  input  wire logic [`PMV_LOW_W-1:0]      op_dest,
  input  wire logic                       tblp_we,
  input  wire logic [`PMV_TBLP_W-1:0]     tblp_wdata,
  input  wire logic [`PMV_NUM_VEC-1:0]    int_en,
  input  wire logic [1:0]                 ext_int_pin,
  input  wire logic [1:0]                 tmr_ovf,
  input  wire logic                       spi_int,
  input  wire logic                       crf_int,
  input  wire logic                       rtc_int,
  input  wire logic                       tbase_int,
  input  wire logic                       adc_int,
  input  wire logic                       xper_int,
  input  wire logic                       prog_we,
  input  wire logic [`PMV_ADDR_W-1:0]     prog_addr,
  input  wire logic [`PMV_WORD_W-1:0]     prog_data,
  output logic      [`PMV_ADDR_W-1:0]     pc,
  output logic      [`PMV_WORD_W-1:0]     instr_word,
  output logic                            instr_valid,
  output logic                            busy,
  output logic                            tbl_wr,
  output logic      [`PMV_LOW_W-1:0]      tbl_dest,
  output logic      [`PMV_LOW_W-1:0]      tbl_data,
  output logic      [`PMV_LOW_W-1:0]      table_high_byte,
  output logic                            int_ack,
  output logic      [2:0]                 int_vec,
  output logic      [`PMV_NUM_VEC-1:0]    int_pend,
  output logic                            stack_full
);

  // ===================================================================
  // Vector table, index 0 is external interrupt 0
  localparam pmv_addr_t VecTbl [`PMV_NUM_VEC] = '{
    `PMV_VEC_EXT0,
    `PMV_VEC_EXT1,
    `PMV_VEC_TMR0,
    `PMV_VEC_TMR1,
    `PMV_VEC_MF0,
    `PMV_VEC_MF1
  };

  // ===================================================================
  // Links and state
  pmv_stk_if stk_if ();                 // Stack link
  pmv_rom_if rom_if ();                 // Store link

  pmv_core_st_t            st_r;        // All core state
  pmv_core_st_t            st_nxt;      // Next state
  logic [`PMV_NUM_VEC-1:0] ready;       // Enabled pending requests
  logic [`PMV_NUM_VEC-1:0] set_ev;      // Request events this cycle
  logic [`PMV_NUM_VEC-1:0] clr_ev;      // Request clear on take
  logic [2:0]              sel;         // Winning vector index
  logic                    take;        // Interrupt taken
  logic                    rd_tbl;      // Store read is a table read
  pmv_addr_t               tbl_addr;    // Table read address

  // ===================================================================
  // Submodules
  // Program store, 4K by 15
  pmv_rom u_rom (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .rom     (rom_if.rom)
  );

  // Return address stack
  pmv_stack u_stack (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .stk     (stk_if.stack)
  );

  // Programmer load path
  assign rom_if.ld_we   = prog_we;
  assign rom_if.ld_addr = prog_addr;
  assign rom_if.ld_data = prog_data;

  // ===================================================================
  // Interrupt arbitration
  // Lowest index wins; blocked while the stack is full
  always_comb begin
    ready = st_r.pend & int_en;
    sel   = 3'h0;
    for (int i = `PMV_NUM_VEC - 1; i >= 0; i--) begin
      if (ready[i]) begin
        sel = 3'(i);
      end
    end
    take = (st_r.state == PMV_ST_RUN) && !op_valid && (|ready)
           && !stk_if.full;
  end

  // ===================================================================
  // Next state
  always_comb begin
    st_nxt        = st_r;
    st_nxt.tbl_wr = 1'b0;
    st_nxt.ack    = 1'b0;
    clr_ev        = '0;
    rd_tbl        = 1'b0;
    stk_if.push      = 1'b0;
    stk_if.pop       = 1'b0;
    stk_if.push_data = st_r.pc + 1'b1;

    // Pin synchronisers, then rising edge detect
    st_nxt.s1   = ext_int_pin;
    st_nxt.s2   = st_r.s1;
    st_nxt.prev = st_r.s2;

    // Request events per vector
    set_ev[1:0] = st_r.s2 & ~st_r.prev;
    set_ev[3:2] = tmr_ovf;
    set_ev[4]   = spi_int | crf_int;
    set_ev[5]   = rtc_int | tbase_int | adc_int | xper_int;

    // Table address: pointer low, page high
    if (op_code == PMV_OP_TBL_LAST) begin
      tbl_addr = {`PMV_LAST_PAGE, st_r.tblp};
    end else begin
      tbl_addr = {st_r.pc[`PMV_ADDR_W-1:`PMV_TBLP_W], st_r.tblp};
    end

    case (st_r.state)
      PMV_ST_RUN: begin
        if (take) begin
          // Save the unexecuted address, enter vector
          stk_if.push      = 1'b1;
          stk_if.push_data = st_r.pc;
          st_nxt.pc        = VecTbl[sel];
          clr_ev[sel]      = 1'b1;
          st_nxt.ack       = 1'b1;
          st_nxt.vec       = sel;
        end else if (op_valid) begin
          case (op_code)
            // Plain step
            PMV_OP_NEXT: begin
              st_nxt.pc = st_r.pc + 1'b1;
            end
            // Skip the following word
            PMV_OP_SKIP: begin
              st_nxt.pc = st_r.pc + 2'h2;
            end
            // Absolute jump
            PMV_OP_JUMP: begin
              st_nxt.pc = op_addr;
            end
            // Subroutine call
            PMV_OP_CALL: begin
              stk_if.push = 1'b1;
              st_nxt.pc   = op_addr;
            end
            // Return from call or interrupt
            PMV_OP_RET: begin
              stk_if.pop = 1'b1;
              st_nxt.pc  = stk_if.top_data;
            end
            // Low byte load keeps the page
            PMV_OP_PCL: begin
              st_nxt.pc = {st_r.pc[`PMV_ADDR_W-1:`PMV_TBLP_W],
                           op_addr[`PMV_TBLP_W-1:0]};
            end
            // Table reads: steal the next store read
            default: begin
              rd_tbl          = 1'b1;
              st_nxt.state    = PMV_ST_TBL;
              st_nxt.busy     = 1'b1;
              st_nxt.tbl_dest = op_dest;
            end
          endcase
        end
      end
      // Second cycle: split the word, resume fetch
      PMV_ST_TBL: begin
        st_nxt.tbl_data = rom_if.rd_data[`PMV_LOW_W-1:0];
        st_nxt.thb      = {1'b0,
                           rom_if.rd_data[`PMV_WORD_W-1:`PMV_LOW_W]};
        st_nxt.tbl_wr   = 1'b1;
        st_nxt.busy     = 1'b0;
        st_nxt.state    = PMV_ST_RUN;
        st_nxt.pc       = st_r.pc + 1'b1;
      end
      default: begin
        st_nxt.state = PMV_ST_RUN;
      end
    endcase

    // Pointer write; old value serves a read issued now
    if (tblp_we) begin
      st_nxt.tblp = tblp_wdata;
    end

    // Set wins over the clear of a take
    st_nxt.pend     = (st_r.pend & ~clr_ev) | set_ev;
    st_nxt.stk_full = stk_if.full;
    st_nxt.ifv      = !rd_tbl;
    rom_if.rd_addr  = rd_tbl ? tbl_addr : st_nxt.pc;
  end

  // ===================================================================
  // State register; high byte has no software write path
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= '0;
      st_r.pc  <= `PMV_VEC_RESET;
      st_r.thb <= `PMV_TABLE_HIGH_BYTE_RST;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ===================================================================
  // Outputs
  assign pc              = st_r.pc;
  assign instr_word      = rom_if.rd_data;
  assign instr_valid     = st_r.ifv;
  assign busy            = st_r.busy;
  assign tbl_wr          = st_r.tbl_wr;
  assign tbl_dest        = st_r.tbl_dest;
  assign tbl_data        = st_r.tbl_data;
  assign table_high_byte = st_r.thb;
  assign int_ack         = st_r.ack;
  assign int_vec         = st_r.vec;
  assign int_pend        = st_r.pend;
  assign stack_full      = st_r.stk_full;

  // ===================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Reset holds the start address
  reset_vec_a: assert property (disable iff (1'b0) !rst_n |-> pc == `PMV_VEC_RESET)
    else $error("pc not at reset vector");

  // Acknowledge lands on the right vector
  vec_ack_a: assert property (int_ack |-> pc == VecTbl[int_vec])
    else $error("interrupt vector mismatch");

  // Shared vector 014H gathers its sources
  mf0_share_a: assert property ((clk_en && (spi_int || crf_int)) |=> int_pend[4])
    else $error("shared vector 0 flag missed");

  // Shared vector 018H gathers its sources
  mf1_share_a: assert property ((clk_en && (rtc_int || tbase_int
    || adc_int || xper_int)) |=> int_pend[5])
    else $error("shared vector 1 flag missed");

  // Full stack withholds acknowledge, flag kept
  full_hold_a: assert property ((clk_en && st_r.state == PMV_ST_RUN && !op_valid
    && stk_if.full && |ready) |=> !int_ack && |(int_pend & $past(ready)))
    else $error("request lost or taken on full stack");

  // Call saves the return address
  call_push_a: assert property ((clk_en && st_r.state == PMV_ST_RUN && op_valid
    && op_code == PMV_OP_CALL) |=> stk_if.top_data == $past(pc) + 1'b1
    && pc == $past(op_addr))
    else $error("call did not push return address");

  // Current page address
  tbl_cur_a: assert property ((st_r.state == PMV_ST_RUN && op_valid && !take
    && op_code == PMV_OP_TBL_CUR) |-> rom_if.rd_addr == {pc[11:8], st_r.tblp})
    else $error("current page table address wrong");

  // Last page address
  tbl_last_a: assert property ((st_r.state == PMV_ST_RUN && op_valid
    && op_code == PMV_OP_TBL_LAST) |-> rom_if.rd_addr == {4'hF, st_r.tblp})
    else $error("last page table address wrong");

  // Two cycles from issue to data
  tbl_two_cyc_a: assert property ((clk_en && st_r.state == PMV_ST_RUN && op_valid
    && op_code inside {PMV_OP_TBL_CUR, PMV_OP_TBL_LAST} ##1 clk_en)
    |-> (busy && !tbl_wr) ##1 (tbl_wr && !busy))
    else $error("table read not two cycles");

  // Word split with zero top bit
  tbl_word_a: assert property (tbl_wr && $rose(tbl_wr)
    |-> {table_high_byte[6:0], tbl_data} == $past(rom_if.rd_data) && !table_high_byte[7])
    else $error("table word split wrong");

  // High byte moves only on a table read
  thb_only_a: assert property ($changed(table_high_byte) |-> tbl_wr)
    else $error("high byte changed without table read");

endmodule

`default_nettype wire

// ---- tb/pmv_cpu_model.sv ----
// Purpose: Core-side model that posts ops, sets the pointer, loads words
// Assumes: Requests change at the falling edge
// Notes:   Released operands and write data show inverted values
`timescale 1ns/1ps
`default_nettype none

module pmv_cpu_model
  import pmv_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        instr_valid,
  input  wire logic        busy,
  output var  logic        op_valid,
  output var  pmv_op_t     op_code,
  output var  logic [11:0] op_addr,
  output var  logic [7:0]  op_dest,
  output var  logic        tblp_we,
  output var  logic [7:0]  tblp_wdata,
  output var  logic        prog_we,
  output var  logic [11:0] prog_addr,
  output var  logic [14:0] prog_data
);
  // =====================================================================
  // Idle levels at time zero
  initial begin
    op_valid = 1'b0;
    op_code = PMV_OP_NEXT;
    op_addr = 12'h000;
    op_dest = 8'h00;
    tblp_we = 1'b0;
    tblp_wdata = 8'h00;
    prog_we = 1'b0;
    prog_addr = 12'h000;
    prog_data = 15'h0000;
  end

  // Post one op once a word is presented; drop it after the taking edge
  task automatic post(input pmv_op_t c, input logic [11:0] a, input logic [7:0] d);
    do @(negedge clk_sys); while (!(instr_valid === 1'b1 && busy === 1'b0));
    op_valid = 1'b1;
    op_code = c;
    op_addr = a;
    op_dest = d;
    @(negedge clk_sys);
    op_valid = 1'b0;
    op_addr = ~a;
    op_dest = ~d;
  endtask

  // One pointer write
  task automatic set_tblp(input logic [7:0] v);
    @(negedge clk_sys);
    tblp_we = 1'b1;
    tblp_wdata = v;
    @(negedge clk_sys);
    tblp_we = 1'b0;
    tblp_wdata = ~v;
  endtask

  // One store load
  task automatic load(input logic [11:0] a, input logic [14:0] w);
    @(negedge clk_sys);
    prog_we = 1'b1;
    prog_addr = a;
    prog_data = w;
    @(negedge clk_sys);
    prog_we = 1'b0;
    prog_data = ~w;
  endtask
endmodule

`default_nettype wire

// ---- tb/test_program_memory_vectors_table_read.sv ----
// Purpose: Self-checking bench of the program memory unit
// Assumes: Core model drives ops; bench drives events at the falling edge
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none

module test_program_memory_vectors_table_read;
  import pmv_pkg::*;

  // =====================================================================
  // Signals
  logic clk_sys = 1'b0;  // System clock
  logic rst_n = 1'b1;  // Reset, active low
  logic [5:0] int_en = 6'h00;  // Vector enables
  logic [9:0] src = 10'h000;  // Event sources
  logic op_valid, tblp_we, prog_we, instr_valid, busy, tbl_wr, int_ack, stack_full;
  pmv_op_t op_code;
  logic [11:0] op_addr, prog_addr, pc;
  logic [14:0] prog_data, instr_word;
  logic [7:0] op_dest, tblp_wdata, tbl_dest, tbl_data, table_high_byte;
  logic [2:0] int_vec;
  logic [5:0] int_pend;
  int n_mismatch = 0;
  int num_checks = 0;
  localparam logic [2:0] VIX [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
                                      3'h4, 3'h5, 3'h5, 3'h5, 3'h5};  // Source to vector

  always #50 clk_sys = ~clk_sys;

  pmv_cpu_model i_cpu (.clk_sys(clk_sys), .instr_valid(instr_valid), .busy(busy),
    .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr), .op_dest(op_dest),
    .tblp_we(tblp_we), .tblp_wdata(tblp_wdata), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data));

  pmv_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_dest(op_dest), .tblp_we(tblp_we),
    .tblp_wdata(tblp_wdata), .int_en(int_en), .ext_int_pin(src[1:0]), .tmr_ovf(src[3:2]),
    .spi_int(src[4]), .crf_int(src[5]), .rtc_int(src[6]), .tbase_int(src[7]),
    .adc_int(src[8]), .xper_int(src[9]), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_data(prog_data), .pc(pc), .instr_word(instr_word), .instr_valid(instr_valid),
    .busy(busy), .tbl_wr(tbl_wr), .tbl_dest(tbl_dest), .tbl_data(tbl_data),
    .table_high_byte(table_high_byte), .int_ack(int_ack), .int_vec(int_vec),
    .int_pend(int_pend), .stack_full(stack_full));

  // =====================================================================
  // Compare and verdict
  task automatic chk(input string what, input logic [14:0] seen, input logic [14:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Wait for an entry, bounded
  task automatic wait_ack;
    for (int n = 0; n < 20 && int_ack !== 1'b1; n++) @(negedge clk_sys);
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_fetch;
    chk("pc", {3'h0, pc}, 15'h0000);
    i_cpu.load(12'hFFF, 15'h4D2B);
    i_cpu.post(PMV_OP_JUMP, 12'hFFF, 8'h00);
    chk("instr", instr_word, 15'h4D2B);
    $display("test fetch done");
  endtask

  task automatic t_table;
    int_en = 6'h00;  // Masked around table reads
    i_cpu.load(12'hF06, 15'h7F5A);
    i_cpu.load(12'h577, 15'h0181);
    i_cpu.post(PMV_OP_JUMP, 12'h523, 8'h00);
    i_cpu.set_tblp(8'h77);
    i_cpu.post(PMV_OP_TBL_CUR, 12'h000, 8'h11);
    chk("busy", {14'h0, busy}, 15'h0001);
    chk("ivalid", {14'h0, instr_valid}, 15'h0000);
    @(negedge clk_sys);
    chk("tbl_wr", {14'h0, tbl_wr}, 15'h0001);
    chk("low", {7'h0, tbl_data}, 15'h0081);
    chk("high", {7'h0, table_high_byte}, 15'h0001);
    i_cpu.set_tblp(8'h06);
    i_cpu.post(PMV_OP_TBL_LAST, 12'h000, 8'h3C);
    @(negedge clk_sys);
    chk("low", {7'h0, tbl_data}, 15'h005A);
    chk("dest", {7'h0, tbl_dest}, 15'h003C);
    chk("high", {7'h0, table_high_byte}, 15'h007F);
    i_cpu.post(PMV_OP_NEXT, 12'h000, 8'h00);
    chk("high", {7'h0, table_high_byte}, 15'h007F);
    $display("test table done");
  endtask

  task automatic t_ints;
    logic [11:0] p0;
    int_en = 6'h3F;
    for (int k = 0; k < 10; k++) begin
      p0 = pc;
      @(negedge clk_sys);
      src[k] = 1'b1;
      @(negedge clk_sys);
      src[k] = 1'b0;
      wait_ack();
      chk("ack", {14'h0, int_ack}, 15'h0001);
      chk("vec", {12'h0, int_vec}, {12'h0, VIX[k]});
      chk("pc", {3'h0, pc}, {10'h0, VIX[k], 2'h0} + 15'h0004);
      i_cpu.post(PMV_OP_RET, 12'h000, 8'h00);
      chk("ret", {3'h0, pc}, {3'h0, p0});
    end
    $display("test vectors done");
  endtask

  task automatic t_stack;
    int n;
    n = 0;
    repeat (6) i_cpu.post(PMV_OP_CALL, 12'h200, 8'h00);
    @(negedge clk_sys);
    chk("full", {14'h0, stack_full}, 15'h0001);
    src[2] = 1'b1;
    @(negedge clk_sys);
    src[2] = 1'b0;
    repeat (10) begin
      @(negedge clk_sys);
      if (int_ack === 1'b1) n++;
    end
    chk("acks", n[14:0], 15'h0000);
    chk("flag", {14'h0, int_pend[2]}, 15'h0001);
    i_cpu.post(PMV_OP_RET, 12'h000, 8'h00);
    wait_ack();
    chk("vec", {12'h0, int_vec}, 15'h0002);
    $display("test stack done");
  endtask

  // Reset in mid-run returns to the start address
  task automatic t_reset;
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("rst pc", {3'h0, pc}, 15'h0000);
    chk("rst high", {7'h0, table_high_byte}, 15'h0000);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("run pc", {3'h0, pc}, 15'h0000);
    chk("ivalid", {14'h0, instr_valid}, 15'h0001);
    chk("full", {14'h0, stack_full}, 15'h0000);
    $display("test reset done");
  endtask

  // =====================================================================
  // Main sequence and watchdog
  initial begin
    #1;
    rst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_fetch();
    t_table();
    t_ints();
    t_stack();
    t_reset();
    wrap_up();
  end

  initial begin
    #3000000;
    n_mismatch++;
    $display("Error watchdog expected done seen hang");
    wrap_up();
  end
endmodule

`default_nettype wire
